// [rtl/resonant_overcurrent_fault_timer.sv]
// Notes on behaviour
// - Sense above shift threshold records an event and pulses discharge switch 5 us.
// - Each new threshold crossing after a pulse ends gives a fresh pulse.
// - Two counters: modulo-128 on switching cycles, modulo-20K on 1 MHz ticks.
// - First event while both counters idle starts both counters.
// - Event before 128 cycles restarts cycle counter; long counter runs on.
// - Each cycle-counter end of count subtracts 32 from long counter, freezes it.
// - Long counter reaching zero stops cycle counter; mechanism returns idle.
// - Event while long counter frozen resumes it and resets cycle counter.
// - Long counter end of count starts soft-stop and stops both counters.
// - Soft-stop holds discharge closed, halts switching after 128 cycles.
// - After soft-stop stay off until supply off, then start-up, restart at on.
// - Long count ends after nominal 20 ms, never under 18 ms.
// - Immediate-stop threshold halts switching at once, discharge held closed.
// - After immediate stop restart only via supply off then on threshold.
// - Immediate-stop comparator ignored until soft-start voltage above minimum.
`timescale 1ns/100ps
`include "ocp_timer_params.svh"

module resonant_overcurrent_fault_timer #(
    parameter int CYCLE_MOD   = `CYCLE_MODULUS,
    parameter int LONG_MOD    = `LONG_MODULUS,
    parameter int LONG_DEC    = `LONG_DECREMENT,
    parameter int PULSE_CYC   = `DISCH_PULSE_CYC,
    parameter int REF_DIV     = `REF_TICK_CYC,
    parameter int STOP_CYCLES = `SOFT_STOP_CYCLES
) (
    input  wire logic                  clock_in,
    input  wire logic                  sys_rst_in,
    input  wire ocp_timer_pkg::sense_t sense_in,
    output logic                       discharge_switch_out,
    output logic                       gate_drive_enable_out,
    output logic                       high_voltage_startup_out,
    output logic                       first_level_overcurrent_event_out,
    output logic                       second_level_overcurrent_stop_out
);
    import ocp_timer_pkg::*;

    localparam int CW = $clog2(CYCLE_MOD + 1);
    localparam int LW = $clog2(LONG_MOD + 1);
    localparam int PW = $clog2(PULSE_CYC + 1);
    localparam int DW = $clog2(REF_DIV + 1);
    localparam int SW = $clog2(STOP_CYCLES + 1);

    sense_t        sync_s;
    logic          shift_d_r;
    logic          cyc_d_r;
    logic          first_level_overcurrent_event;
    logic          cyc_tick;
    logic          ref_tick;
    stage_state_t  state_r,     state_nxt;
    logic [PW-1:0] pulse_r,     pulse_nxt;
    logic [DW-1:0] div_r,       div_nxt;
    logic [CW-1:0] cyc_cnt_r,   cyc_cnt_nxt;
    logic [LW-1:0] long_cnt_r,  long_cnt_nxt;
    logic          active_r,    active_nxt;
    logic          frozen_r,    frozen_nxt;
    logic [SW-1:0] stop_cnt_r,  stop_cnt_nxt;
    logic          disch_nxt;
    logic          gate_nxt;
    logic          high_voltage_startup_nxt;
    logic          first_level_overcurrent_event_nxt;
    logic          second_level_overcurrent_stop_nxt;

    // Comparator and supply levels come from the analog side, so synchronise
    input_sync #(
        .WIDTH ($bits(sense_t))
    ) u_sync (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .async_in   (sense_in),
        .sync_out   (sync_s)
    );

    // Edge detect on the synchronised comparator and switching-cycle inputs
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            shift_d_r <= 1'b0;
            cyc_d_r   <= 1'b0;
        end
        else
        begin
            shift_d_r <= sync_s.frequency_shift_threshold;
            cyc_d_r   <= sync_s.switching_cycle;
        end
    end

    // A crossing only counts once the previous pulse is over
    assign first_level_overcurrent_event     = sync_s.frequency_shift_threshold && !shift_d_r
                      && (pulse_r == '0) && (state_r == ST_RUN);
    assign cyc_tick = sync_s.switching_cycle && !cyc_d_r;
    assign ref_tick = (div_r == DW'(REF_DIV - 1));

    // Overload timing, stage sequencing and output values
    always_comb
    begin
        state_nxt    = state_r;
        pulse_nxt    = pulse_r;
        cyc_cnt_nxt  = cyc_cnt_r;
        long_cnt_nxt = long_cnt_r;
        active_nxt   = active_r;
        frozen_nxt   = frozen_r;
        stop_cnt_nxt = stop_cnt_r;
        div_nxt      = ref_tick ? '0 : div_r + 1'b1;
        first_level_overcurrent_event_nxt     = first_level_overcurrent_event;
        second_level_overcurrent_stop_nxt     = second_level_overcurrent_stop_out;

        // Fixed-length discharge pulse
        if (first_level_overcurrent_event)
            pulse_nxt = PW'(PULSE_CYC);
        else if (pulse_r != '0)
            pulse_nxt = pulse_r - 1'b1;

        unique case (state_r)
            ST_OFF:
            begin
                // Powered-up start waits for the on threshold
                if (sync_s.supply_on_threshold)
                    state_nxt = ST_RUN;
            end
            ST_RUN:
            begin
                // Second-level trip is masked while soft-start is low
                if (sync_s.immediate_stop_threshold && sync_s.soft_start_above_min)
                begin
                    state_nxt = ST_HARD_STOP;
                    second_level_overcurrent_stop_nxt  = 1'b1;
                end
                else if (first_level_overcurrent_event)
                begin
                    cyc_cnt_nxt = '0;
                    active_nxt  = 1'b1;
                    frozen_nxt  = 1'b0;
                    if (!active_r)
                        long_cnt_nxt = '0;
                    else if (!frozen_r && ref_tick)
                        long_cnt_nxt = long_cnt_r + 1'b1;
                end
                else if (active_r)
                begin
                    if (!frozen_r && ref_tick)
                        long_cnt_nxt = long_cnt_r + 1'b1;
                    if (cyc_tick)
                    begin
                        if (cyc_cnt_r == CW'(CYCLE_MOD - 1))
                        begin
                            cyc_cnt_nxt = '0;
                            frozen_nxt  = 1'b1;
                            // Saturate at zero: counter may sit below the step
                            if (long_cnt_r <= LW'(LONG_DEC))
                            begin
                                long_cnt_nxt = '0;
                                active_nxt   = 1'b0;
                                frozen_nxt   = 1'b0;
                            end
                            else
                                long_cnt_nxt = long_cnt_r - LW'(LONG_DEC);
                        end
                        else
                            cyc_cnt_nxt = cyc_cnt_r + 1'b1;
                    end
                end
                // End of the long count wins over a same-cycle decrement
                if (active_r && !frozen_r && ref_tick && long_cnt_r == LW'(LONG_MOD - 1)
                    && state_nxt == ST_RUN)
                begin
                    state_nxt    = ST_SOFT_STOP;
                    active_nxt   = 1'b0;
                    frozen_nxt   = 1'b0;
                    cyc_cnt_nxt  = '0;
                    long_cnt_nxt = '0;
                    stop_cnt_nxt = '0;
                end
            end
            ST_SOFT_STOP:
            begin
                // A dead short still trips during soft-stop; otherwise switching runs a fixed count
                if (sync_s.immediate_stop_threshold && sync_s.soft_start_above_min)
                begin
                    state_nxt = ST_HARD_STOP;
                    second_level_overcurrent_stop_nxt  = 1'b1;
                end
                else if (cyc_tick)
                begin
                    if (stop_cnt_r == SW'(STOP_CYCLES - 1))
                        state_nxt = ST_WAIT_ON;
                    else
                        stop_cnt_nxt = stop_cnt_r + 1'b1;
                end
            end
            ST_HARD_STOP:
            begin
                // Latched until supply has collapsed
                if (sync_s.supply_off_threshold)
                    state_nxt = ST_WAIT_ON;
            end
            ST_WAIT_ON:
            begin
                // Supply recharges through start-up; restart from clean state
                if (sync_s.supply_on_threshold && !sync_s.supply_off_threshold)
                begin
                    state_nxt    = ST_RUN;
                    active_nxt   = 1'b0;
                    frozen_nxt   = 1'b0;
                    cyc_cnt_nxt  = '0;
                    long_cnt_nxt = '0;
                    pulse_nxt    = '0;
                    second_level_overcurrent_stop_nxt     = 1'b0;
                end
            end
        endcase

        // Soft-stop after expiry must first see supply fall
        if (state_r == ST_SOFT_STOP && state_nxt == ST_WAIT_ON && !sync_s.supply_off_threshold)
            state_nxt = ST_HARD_STOP;

        disch_nxt = (pulse_nxt != '0) || (state_nxt != ST_RUN);
        gate_nxt  = (state_nxt == ST_RUN) || (state_nxt == ST_SOFT_STOP);
        high_voltage_startup_nxt  = (state_nxt == ST_WAIT_ON) || (state_nxt == ST_OFF);
    end

    // State registers; outputs straight from flip-flops
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            state_r                           <= ST_OFF;
            pulse_r                           <= '0;
            div_r                             <= '0;
            cyc_cnt_r                         <= '0;
            long_cnt_r                        <= '0;
            active_r                          <= 1'b0;
            frozen_r                          <= 1'b0;
            stop_cnt_r                        <= '0;
            discharge_switch_out              <= 1'b1;
            gate_drive_enable_out             <= 1'b0;
            high_voltage_startup_out          <= 1'b1;
            first_level_overcurrent_event_out <= 1'b0;
            second_level_overcurrent_stop_out <= 1'b0;
        end
        else
        begin
            state_r                           <= state_nxt;
            pulse_r                           <= pulse_nxt;
            div_r                             <= div_nxt;
            cyc_cnt_r                         <= cyc_cnt_nxt;
            long_cnt_r                        <= long_cnt_nxt;
            active_r                          <= active_nxt;
            frozen_r                          <= frozen_nxt;
            stop_cnt_r                        <= stop_cnt_nxt;
            discharge_switch_out              <= disch_nxt;
            gate_drive_enable_out             <= gate_nxt;
            high_voltage_startup_out          <= high_voltage_startup_nxt;
            first_level_overcurrent_event_out <= first_level_overcurrent_event_nxt;
            second_level_overcurrent_stop_out <= second_level_overcurrent_stop_nxt;
        end
    end

endmodule

// [rtl/ocp_timer_params.svh]
`ifndef OCP_TIMER_PARAMS_SVH
`define OCP_TIMER_PARAMS_SVH

// System clock period in ns (20 MHz)
`define CLK_PERIOD_NS        50
// Discharge pulse after a first-level event, in ns (5 us)
`define DISCH_PULSE_NS       5000
// Discharge pulse length in clock cycles
`define DISCH_PULSE_CYC      ((`DISCH_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Reference tick period in ns (about 1 MHz)
`define REF_TICK_NS          1000
// Reference tick divider in clock cycles
`define REF_TICK_CYC         (`REF_TICK_NS / `CLK_PERIOD_NS)
// Cycle counter modulus (switching cycles)
`define CYCLE_MODULUS        128
// Long counter modulus (reference ticks, 20K)
`define LONG_MODULUS         20000
// Amount taken off the long counter at each cycle-counter end of count
`define LONG_DECREMENT       32
// Switching cycles of soft-stop before halting
`define SOFT_STOP_CYCLES     128
// Nominal and least overload run time in ms
`define LONG_NOMINAL_MS      20
`define LONG_MIN_MS          18

`endif

// [rtl/ocp_timer_pkg.sv]
package ocp_timer_pkg;

    // Comparator and supply inputs gathered together
    typedef struct packed {
        logic frequency_shift_threshold;
        logic immediate_stop_threshold;
        logic soft_start_above_min;
        logic supply_off_threshold;
        logic supply_on_threshold;
        logic switching_cycle;
    } sense_t;

    // Stage state
    typedef enum logic [2:0] {
        ST_OFF,
        ST_RUN,
        ST_SOFT_STOP,
        ST_HARD_STOP,
        ST_WAIT_ON
    } stage_state_t;

endpackage

// [rtl/input_sync.sv]
`timescale 1ns/100ps

// Two-stage synchroniser for a bundle of asynchronous inputs
module input_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             clock_in,
    input  wire logic             sys_rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_nxt;

    // First stage feeds the second only
    always_comb
    begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    // Both stages clear on reset
    always_ff @(posedge clock_in)
    begin
        if (sys_rst_in)
        begin
            meta_r   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r   <= meta_nxt;
            sync_out <= sync_nxt;
        end
    end

endmodule

// [testbench/ocp_fault_chk.sv]
`timescale 1ns/100ps
// Port-level watcher for the overcurrent timer
module ocp_fault_chk #(
    parameter int PULSE_CYC = 100
) (
    input  wire logic                  clock_in,
    input  wire logic                  sys_rst_in,
    input  wire ocp_timer_pkg::sense_t sense_in,
    input  wire logic                  discharge_switch_out,
    input  wire logic                  gate_drive_enable_out,
    input  wire logic                  high_voltage_startup_out,
    input  wire logic                  first_level_overcurrent_event_out,
    input  wire logic                  second_level_overcurrent_stop_out
);
    import ocp_timer_pkg::*;
    // Short aliases keep the properties readable
    wire ev = first_level_overcurrent_event_out;
    wire ds = discharge_switch_out;
    wire gt = gate_drive_enable_out;
    wire st = second_level_overcurrent_stop_out;
    // Cycles of the discharge pulse elapsed since an event
    int pc_r;
    int pc_nxt;
    always_comb pc_nxt = ev ? 1 : (pc_r != 0 && pc_r < PULSE_CYC - 1) ? pc_r + 1 : 0;
    always_ff @(posedge clock_in) pc_r <= sys_rst_in ? 0 : pc_nxt;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    property p_ev_disch; ev |-> ds; endproperty
    a_ev_disch: assert property (p_ev_disch) else $error("event without discharge");
    property p_pulse_len; pc_r != 0 |-> ds; endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("discharge pulse too short");
    property p_ev_gap; pc_r != 0 |-> !ev; endproperty
    a_ev_gap: assert property (p_ev_gap) else $error("event inside a pulse");
    property p_stop_off; st |-> !gt && ds; endproperty
    a_stop_off: assert property (p_stop_off) else $error("stop latched while driving");
    // Gate still high five cycles into a qualified hard short means the stop was missed
    property p_stop_fast;
        (gt && sense_in.immediate_stop_threshold && sense_in.soft_start_above_min) [*5] |-> st;
    endproperty
    a_stop_fast: assert property (p_stop_fast) else $error("hard short not acted on");
    property p_mask; (!sense_in.soft_start_above_min && !st) [*4] |=> !st; endproperty
    a_mask: assert property (p_mask) else $error("stop while soft-start low");
    property p_stop_hold; (st && !sense_in.supply_on_threshold) [*3] |=> st; endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop cleared without supply");
    property p_rise_clear; $rose(gt) |-> !st; endproperty
    a_rise_clear: assert property (p_rise_clear) else $error("restart with stop latched");
    property p_off_disch; !gt |-> ds; endproperty
    a_off_disch: assert property (p_off_disch) else $error("discharge open while off");
    property p_hv_off; gt |-> !high_voltage_startup_out; endproperty
    a_hv_off: assert property (p_hv_off) else $error("start-up source on while running");
endmodule

bind resonant_overcurrent_fault_timer ocp_fault_chk #(.PULSE_CYC(PULSE_CYC)) i_ocp_fault_chk (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .sense_in(sense_in),
    .discharge_switch_out(discharge_switch_out), .gate_drive_enable_out(gate_drive_enable_out),
    .high_voltage_startup_out(high_voltage_startup_out),
    .first_level_overcurrent_event_out(first_level_overcurrent_event_out),
    .second_level_overcurrent_stop_out(second_level_overcurrent_stop_out)
);

// [testbench/hb_stage_model.sv]
`timescale 1ns/100ps
// Half-bridge stage with tank sensing, as the timer sees it
module hb_stage_model (
    input  wire logic           clock_in,
    input  wire logic           gate_in,
    input  wire logic           discharge_in,
    input  wire logic           overload_in,
    input  wire logic           dead_short_in,
    input  wire logic           soft_start_up_in,
    input  wire logic           vcc_on_in,
    input  wire logic           vcc_off_in,
    output ocp_timer_pkg::sense_t sense_out
);
    import ocp_timer_pkg::*;
    // Switching stands still while the drivers are off; no current flows then
    always @(posedge clock_in)
    begin
        sense_out.switching_cycle           <= gate_in & ~sense_out.switching_cycle;
        sense_out.frequency_shift_threshold <= overload_in & gate_in & ~discharge_in; // Discharge lifts frequency
        sense_out.immediate_stop_threshold  <= dead_short_in & gate_in;
        sense_out.soft_start_above_min      <= soft_start_up_in;
        sense_out.supply_off_threshold      <= vcc_off_in;
        sense_out.supply_on_threshold       <= vcc_on_in;
    end
endmodule

// [testbench/resonant_overcurrent_fault_timer_bench.sv]
`timescale 1ns/100ps
module resonant_overcurrent_fault_timer_bench;
    import ocp_timer_pkg::*;
    // Shortened counts keep the run brief
    localparam int PULSE = 4;
    localparam int REFD  = 2;
    localparam int LMOD  = 200;
    logic   clock_in   = 1'b0;
    logic   sys_rst_in = 1'b1;
    logic   ovl        = 1'b0;
    logic   dshort     = 1'b0;
    logic   ssmin      = 1'b1;
    logic   von        = 1'b0;
    logic   voff       = 1'b0;
    sense_t sense;
    logic   disch, gate, hv, ev, stop;
    int     n_mismatch = 0;
    int     n_compared = 0;
    int     i, n, t0;

    always #25 clock_in = ~clock_in;

    resonant_overcurrent_fault_timer #(.CYCLE_MOD(8), .LONG_MOD(LMOD), .LONG_DEC(2), .PULSE_CYC(PULSE),
        .REF_DIV(REFD), .STOP_CYCLES(8)) i_resonant_overcurrent_fault_timer (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .sense_in(sense), .discharge_switch_out(disch),
        .gate_drive_enable_out(gate), .high_voltage_startup_out(hv),
        .first_level_overcurrent_event_out(ev), .second_level_overcurrent_stop_out(stop));
    hb_stage_model i_hb_stage_model (.clock_in(clock_in), .gate_in(gate), .discharge_in(disch),
        .overload_in(ovl), .dead_short_in(dshort), .soft_start_up_in(ssmin), .vcc_on_in(von),
        .vcc_off_in(voff), .sense_out(sense));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Sample just after the edge so the design's updates have landed
    task automatic tick(input int k);
        repeat (k) @(posedge clock_in);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Hiccup: held off, start-up source after supply falls, restart at on level
    task automatic t_supply;
        tick(40);
        chk("gate held off", gate, 0);
        chk("startup idle", hv, 0);
        @(posedge clock_in);
        von <= 1'b0;
        voff <= 1'b1;
        tick(8);
        chk("startup on", hv, 1);
        chk("still off", gate, 0);
        @(posedge clock_in);
        voff <= 1'b0;
        von <= 1'b1;
        for (i = 0; i < 20 && gate !== 1'b1; i++) tick(1);
        chk("restart", gate, 1);
    endtask
    task automatic t_reset;
        chk("reset discharge", disch, 1);
        chk("reset gate", gate, 0);
        chk("reset startup", hv, 1);
        chk("reset stop", stop, 0);
        @(posedge clock_in);
        von <= 1'b1;
        for (i = 0; i < 20 && gate !== 1'b1; i++) tick(1);
        chk("power up", gate, 1);
        chk("discharge open", disch, 0);
        $display("done: reset and power up");
    endtask
    // One event then quiet: long count freezes and drains to idle
    task automatic t_single;
        @(posedge clock_in);
        ovl <= 1'b1;
        @(posedge clock_in);
        ovl <= 1'b0;
        for (i = 0; i < 20 && ev !== 1'b1; i++) tick(1);
        chk("event", ev, 1);
        for (n = 0; n < 50 && disch === 1'b1; n++) tick(1);
        chk("pulse width", n, PULSE);
        tick(500); // Long enough that a count that never froze would expire
        chk("no soft stop", gate, 1);
        $display("done: single event");
    endtask
    // Lasting overload: repeated pulses, full long count from idle, then soft-stop
    task automatic t_overload;
        @(posedge clock_in);
        ovl <= 1'b1;
        n = 0;
        t0 = 0;
        for (i = 0; i < 1000 && gate === 1'b1; i++)
        begin
            if (ev === 1'b1) n++;
            if (disch !== 1'b1) t0 = i;
            tick(1);
        end
        chk("repeat events", n > 10, 1);
        chk("run not short", i >= LMOD * REFD, 1);
        chk("run bounded", i <= LMOD * REFD + 60, 1);
        chk("soft stop span", i - t0 >= 16, 1);
        @(posedge clock_in);
        ovl <= 1'b0;
        t_supply;
        $display("done: overload");
    endtask
    // Overload, a quiet gap that freezes the long count, then overload resumes it from there
    task automatic t_resume;
        @(posedge clock_in);
        ovl <= 1'b1;
        repeat (LMOD) @(posedge clock_in);
        ovl <= 1'b0;
        tick(40);
        chk("frozen not expired", gate, 1);
        @(posedge clock_in);
        ovl <= 1'b1;
        for (i = 0; i < 1000 && gate === 1'b1; i++) tick(1);
        chk("long count resumed", i < LMOD * REFD, 1);
        chk("resumed run stops", gate, 0);
        @(posedge clock_in);
        ovl <= 1'b0;
        t_supply;
        $display("done: resume after freeze");
    endtask
    // Hard short masked until soft-start is up, then immediate latched stop
    task automatic t_short;
        @(posedge clock_in);
        ssmin <= 1'b0;
        dshort <= 1'b1;
        tick(20);
        chk("short masked", stop, 0);
        chk("still running", gate, 1);
        @(posedge clock_in);
        ssmin <= 1'b1;
        for (i = 0; i < 10 && stop !== 1'b1; i++) tick(1);
        chk("stop latched", stop, 1);
        chk("gate off", gate, 0);
        chk("discharge held", disch, 1);
        @(posedge clock_in);
        dshort <= 1'b0;
        t_supply;
        chk("stop cleared", stop, 0);
        $display("done: hard short");
    endtask

    // Main sequence
    initial
    begin
        repeat (2) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        tick(1);
        t_reset;
        t_single;
        t_overload;
        t_resume;
        t_short;
        tally_and_finish;
    end
    // The run needs about 1500 cycles; four times that means a hang
    initial
    begin
        #(6000 * 50);
        n_mismatch++;
        tally_and_finish;
    end
endmodule
